//--- pkg/can_rx_defines.vh
// Register offsets, field positions and reset values of the receive buffer.
// Included by the design files; definitions only.
`ifndef CAN_RX_DEFINES_VH
`define CAN_RX_DEFINES_VH

`define OFS_IDENT_HIGH 12'h000
`define OFS_IDENT_LOW 12'h004
`define OFS_EXT_HIGH 12'h008
`define OFS_EXT_LOW 12'h00c
`define OFS_LENGTH 12'h010
`define OFS_BUF_CTRL 12'h014
`define OFS_ERR_COUNT 12'h018
`define OFS_INT_STATUS 12'h01c
`define OFS_INT_MASK 12'h020
`define OFS_DATA_BASE 12'h040
`define OFS_DATA_LAST 12'h05c

`define BIT_SRR 4
`define BIT_EXT 3
`define BIT_RTR_LEN 6
`define BIT_RTR_CTRL 3
`define BIT_FULL 7

`define INT_RX_DONE 0
`define INT_PASSIVE 1
`define INT_OVERRUN 2
`define INT_WIDTH 3

`define ERR_PASSIVE_LIMIT 8'h7f
`define ERR_COUNT_RESET 8'h00
`define DLC_MAX 4'h8

`endif

//--- src/can_rx_err_counter.v
// Receive error counter: the increment step is chosen by the protocol engine; decrement is by one.
// Assumes err_inc, err_dec and recover come from logic on ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "can_rx_defines.vh"

module can_rx_err_counter (
  input wire ref_clk,
  input wire rst_n,
  input wire err_inc,
  input wire [3:0] inc_step,
  input wire err_dec,
  input wire recover,
  output reg [7:0] count_ff,
  output wire passive
);

  reg [7:0] nxt_count;
  wire [8:0] sum;

  assign sum = {1'b0, count_ff} + {5'h00, inc_step};

  // --------------------------------------------------------------
  // Counting
  // --------------------------------------------------------------
  // Saturates instead of wrapping so a long error burst never looks
  // like a healthy bus.
  always @*
  begin
    nxt_count = count_ff;
    if (recover)
      nxt_count = `ERR_COUNT_RESET;
    else if (err_inc)
      nxt_count = sum[8] ? 8'hff : sum[7:0];
    else if (err_dec && count_ff != 8'h00)
      nxt_count = count_ff - 8'h01;
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      count_ff <= `ERR_COUNT_RESET; // see [R11]
    else
      count_ff <= nxt_count; // see [R11]
  end

  assign passive = (count_ff > `ERR_PASSIVE_LIMIT); // see [R12]

endmodule // can_rx_err_counter

`default_nettype wire

//--- src/can_rx_buffer.v
// CAN receive buffer registers and receive error counter, APB slave.
// Assumes a protocol engine on ref_clk presents whole accepted frames.
// Operation
// [R1] Ident high byte holds id 10..3 standard, or 28..21 extended.
// [R2] Ident low bits 7..5 hold id 2..0, or extended id 20..18.
// [R3] Substitute remote bit is 0 extended, else the buffer remote status.
// [R4] Extended flag bit 3 set for extended frames, clear for standard.
// [R5] Ident low bits 1..0 hold extended id bits 17 and 16.
// [R6] Extended high byte holds extended id bits 15..8.
// [R7] Extended low byte holds extended id bits 7..0.
// [R8] Length bits 3..0 hold the code; 9 to 15 are invalid.
// [R9] Eight data byte registers, index 0 to 7, in received order.
// [R10] Unimplemented bits read as zero.
// [R11] Eight-bit read-only error counter, zero after reset.
// [R12] Count above 127 puts the controller in error passive.
// [R13] The error count never causes bus-off on its own.
// [R14] Length bit 6 is the remote request flag; bits 7,5,4 read 0.
// [R15] All fields are loaded together from one accepted frame.
// [R16] Control bit 3 is a read-only remote request flag.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "can_rx_defines.vh"

module can_rx_buffer (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire frame_valid,
  input wire [28:0] frame_ident,
  input wire frame_extended,
  input wire frame_remote,
  input wire [3:0] frame_length,
  input wire [63:0] frame_data,
  input wire err_inc,
  input wire [3:0] err_step,
  input wire err_dec,
  input wire err_recover,
  output wire error_passive,
  output wire bus_off,
  output wire irq
);

  reg [7:0] ident_high_ff;
  reg [2:0] ident_mid_ff;
  reg [1:0] ident_top_ext_ff;
  reg extended_frame_flag_ff;
  reg [7:0] ext_high_ff;
  reg [7:0] ext_low_ff;
  reg remote_request_flag_ff;
  reg [3:0] length_ff;
  reg [7:0] data_ff [0:7];
  reg full_ff;
  reg [`INT_WIDTH-1:0] int_status_ff;
  reg [`INT_WIDTH-1:0] int_mask_ff;
  reg passive_prev_ff;
  reg [31:0] nxt_prdata;
  reg addr_ok;
  wire [7:0] rx_error_count;
  wire passive;
  wire wr_en;
  wire rd_en;
  wire [7:0] ident_low_flags;
  wire [7:0] length_reg;
  wire [7:0] ctrl_reg;
  wire [`INT_WIDTH-1:0] events;
  wire data_sel;
  wire [2:0] data_idx;
  wire sel_ident_high;
  wire sel_ident_low;
  wire sel_ext_high;
  wire sel_ext_low;
  wire sel_length;
  wire sel_ctrl;
  wire sel_err_count;
  wire sel_int_status;
  wire sel_int_mask;
  wire [7:0] data_wr;
  wire [`INT_WIDTH-1:0] int_clear;
  reg nxt_full;
  reg [`INT_WIDTH-1:0] nxt_int_status;

  // --------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !addr_ok;
  assign data_sel = (paddr >= `OFS_DATA_BASE) && (paddr <= `OFS_DATA_LAST)
    && (paddr[1:0] == 2'b00);
  assign data_idx = paddr[4:2];

  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------
  // One decode feeds both the write strobes and the read mux, so the
  // two paths can never disagree about which word an address selects.
  assign sel_ident_high = (paddr == `OFS_IDENT_HIGH);
  assign sel_ident_low = (paddr == `OFS_IDENT_LOW);
  assign sel_ext_high = (paddr == `OFS_EXT_HIGH);
  assign sel_ext_low = (paddr == `OFS_EXT_LOW);
  assign sel_length = (paddr == `OFS_LENGTH);
  assign sel_ctrl = (paddr == `OFS_BUF_CTRL);
  assign sel_err_count = (paddr == `OFS_ERR_COUNT);
  assign sel_int_status = (paddr == `OFS_INT_STATUS);
  assign sel_int_mask = (paddr == `OFS_INT_MASK);

  // --------------------------------------------------------------
  // Frame capture
  // --------------------------------------------------------------
  // The whole frame lands in one edge, so a read sequence between two
  // arrivals never mixes fields. Software may still write the fields.
  // Each register takes a frame before a bus write in the same cycle, and
  // a standard frame zeroes the extended bytes so no old id bits linger.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      ident_high_ff <= 8'h00;
    else if (frame_valid)
      ident_high_ff <= frame_extended ? frame_ident[28:21]
        : frame_ident[10:3]; // see [R1] [R15]
    else if (wr_en && sel_ident_high)
      ident_high_ff <= pwdata[7:0];
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      ident_mid_ff <= 3'h0;
    else if (frame_valid)
      ident_mid_ff <= frame_extended ? frame_ident[20:18]
        : frame_ident[2:0]; // see [R2]
    else if (wr_en && sel_ident_low)
      ident_mid_ff <= pwdata[7:5];
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      ident_top_ext_ff <= 2'h0;
    else if (frame_valid)
      ident_top_ext_ff <= frame_extended ? frame_ident[17:16]
        : 2'h0; // see [R5]
    else if (wr_en && sel_ident_low)
      ident_top_ext_ff <= pwdata[1:0];
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      extended_frame_flag_ff <= 1'b0;
    else if (frame_valid)
      extended_frame_flag_ff <= frame_extended; // see [R4]
    else if (wr_en && sel_ident_low)
      extended_frame_flag_ff <= pwdata[`BIT_EXT];
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      ext_high_ff <= 8'h00;
    else if (frame_valid)
      ext_high_ff <= frame_extended ? frame_ident[15:8]
        : 8'h00; // see [R6]
    else if (wr_en && sel_ext_high)
      ext_high_ff <= pwdata[7:0];
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      ext_low_ff <= 8'h00;
    else if (frame_valid)
      ext_low_ff <= frame_extended ? frame_ident[7:0]
        : 8'h00; // see [R7]
    else if (wr_en && sel_ext_low)
      ext_low_ff <= pwdata[7:0];
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      remote_request_flag_ff <= 1'b0;
    else if (frame_valid)
      remote_request_flag_ff <= frame_remote; // see [R14] [R16]
    else if (wr_en && sel_length)
      remote_request_flag_ff <= pwdata[`BIT_RTR_LEN];
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      length_ff <= 4'h0;
    else if (frame_valid)
      length_ff <= frame_length; // see [R8]
    else if (wr_en && sel_length)
      length_ff <= pwdata[3:0];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_data
      localparam [2:0] byte_idx = gi;
      assign data_wr[gi] = wr_en && data_sel && (data_idx == byte_idx);
      always @(posedge ref_clk)
      begin
        if (!rst_n)
          data_ff[gi] <= 8'h00;
        else if (frame_valid)
          data_ff[gi] <= frame_data[63-8*gi -: 8]; // see [R9] [R15]
        else if (data_wr[gi])
          data_ff[gi] <= pwdata[7:0];
      end
    end
  endgenerate

  // --------------------------------------------------------------
  // Buffer full flag and interrupts
  // --------------------------------------------------------------
  // Full is set by a frame and cleared by writing zero to bit 7; a frame
  // arriving in the clearing cycle wins. A frame over a full buffer
  // overwrites it and flags overrun.
  always @*
  begin
    nxt_full = full_ff;
    if (frame_valid)
      nxt_full = 1'b1;
    else if (wr_en && sel_ctrl && !pwdata[`BIT_FULL])
      nxt_full = 1'b0;
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
      full_ff <= 1'b0;
    else
      full_ff <= nxt_full;
  end

  assign events = {frame_valid && full_ff,
    passive && !passive_prev_ff, frame_valid};
  assign int_clear = (wr_en && sel_int_status) ?
    pwdata[`INT_WIDTH-1:0] : {`INT_WIDTH{1'b0}};

  // An event in the clearing cycle survives, so no edge is ever lost.
  always @*
  begin
    nxt_int_status = (int_status_ff & ~int_clear) | events;
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      int_status_ff <= {`INT_WIDTH{1'b0}};
      int_mask_ff <= {`INT_WIDTH{1'b0}};
      passive_prev_ff <= 1'b0;
    end
    else
    begin
      passive_prev_ff <= passive;
      int_status_ff <= nxt_int_status;
      if (wr_en && sel_int_mask)
        int_mask_ff <= pwdata[`INT_WIDTH-1:0];
    end
  end

  assign irq = |(int_status_ff & int_mask_ff);

  // --------------------------------------------------------------
  // Error counter
  // --------------------------------------------------------------
  can_rx_err_counter u_err (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .err_inc(err_inc),
    .inc_step(err_step),
    .err_dec(err_dec),
    .recover(err_recover),
    .count_ff(rx_error_count),
    .passive(passive)
  );

  assign error_passive = passive; // see [R12]
  // Bus-off belongs to the transmit count, which lives elsewhere.
  assign bus_off = 1'b0; // see [R13]

  // --------------------------------------------------------------
  // Read back
  // --------------------------------------------------------------
  assign ident_low_flags = {ident_mid_ff,
    remote_request_flag_ff && !extended_frame_flag_ff, // see [R3]
    extended_frame_flag_ff, 1'b0, ident_top_ext_ff}; // see [R10]
  assign length_reg = {1'b0, remote_request_flag_ff, 2'b00, length_ff}; // see [R14]
  assign ctrl_reg = {full_ff, 3'b000, remote_request_flag_ff, 3'b000}; // see [R16]

  always @*
  begin
    nxt_prdata = 32'h0000_0000;
    addr_ok = 1'b1;
    if (sel_ident_high)
      nxt_prdata[7:0] = ident_high_ff;
    else if (sel_ident_low)
      nxt_prdata[7:0] = ident_low_flags;
    else if (sel_ext_high)
      nxt_prdata[7:0] = ext_high_ff;
    else if (sel_ext_low)
      nxt_prdata[7:0] = ext_low_ff;
    else if (sel_length)
      nxt_prdata[7:0] = length_reg;
    else if (sel_ctrl)
      nxt_prdata[7:0] = ctrl_reg;
    else if (sel_err_count)
      nxt_prdata[7:0] = rx_error_count; // see [R11]
    else if (sel_int_status)
      nxt_prdata[`INT_WIDTH-1:0] = int_status_ff;
    else if (sel_int_mask)
      nxt_prdata[`INT_WIDTH-1:0] = int_mask_ff;
    else if (data_sel)
      nxt_prdata[7:0] = data_ff[data_idx];
    else
      addr_ok = 1'b0;
  end

  // Read data is sampled in the setup cycle so it is stable in access.
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      prdata <= nxt_prdata;
  end

endmodule // can_rx_buffer

`default_nettype wire

//--- bench/can_rx_buffer_props.sv
// Port checker for the receive buffer block.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module can_rx_buffer_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_valid,
  input wire logic err_inc,
  input wire logic err_dec,
  input wire logic err_recover,
  input wire logic error_passive,
  input wire logic bus_off
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  a_no_bus_off: assert property (!bus_off)
    else $error("bus off raised");
  a_zero_wait: assert property (acc |-> pready)
    else $error("access phase stalled");
  a_recover_clears: assert property (
    err_recover |=> !error_passive)
    else $error("passive after recover");
  a_passive_hold: assert property (
    !err_inc && !err_dec && !err_recover |=> $stable(error_passive))
    else $error("passive moved without event");
  a_passive_rise: assert property (
    $rose(error_passive) |-> $past(err_inc))
    else $error("passive rose without increment");
  a_passive_fall: assert property (
    $fell(error_passive) |-> $past(err_dec) || $past(err_recover))
    else $error("passive fell without decrement");
  a_upper_zero: assert property (
    acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (
    acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_mapped_ok: assert property (
    acc && paddr[1:0] == 2'b00 && paddr <= 12'h020 |-> !pslverr)
    else $error("mapped address refused");
  a_len_reserved: assert property (
    acc && !pwrite && paddr == 12'h010 |-> (prdata[7:4] & 4'hb) == 4'h0)
    else $error("length reserved bits set");
  c_frame: cover property (frame_valid);
  c_passive: cover property ($rose(error_passive));
  c_refused: cover property (acc && pslverr);
endmodule // can_rx_buffer_props
bind can_rx_buffer can_rx_buffer_props can_rx_buffer_props_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .frame_valid(frame_valid), .err_inc(err_inc),
  .err_dec(err_dec), .err_recover(err_recover),
  .error_passive(error_passive), .bus_off(bus_off));
`default_nettype wire

//--- bench/can_node_model.sv
// Remote node model: hands one accepted frame at a time to the buffer.
// Assumes the caller runs on ref_clk; fields turn over once released.
`timescale 1ns/10ps
`default_nettype none
module can_node_model (
  input wire logic ref_clk,
  output logic frame_valid,
  output logic [28:0] frame_ident,
  output logic frame_extended,
  output logic frame_remote,
  output logic [3:0] frame_length,
  output logic [63:0] frame_data
);
  initial
  begin
    {frame_valid, frame_extended, frame_remote} = 3'h0;
    {frame_ident, frame_length, frame_data} = '0;
  end
  task automatic send(input logic ext, input logic rtr,
    input logic [28:0] id, input logic [3:0] len, input logic [63:0] d);
    @(posedge ref_clk);
    frame_valid <= 1'b1;
    {frame_extended, frame_remote, frame_ident} <= {ext, rtr, id};
    {frame_length, frame_data} <= {len, d};
    @(posedge ref_clk);
    // Stale ident, length and data fields are inverted so a late sample cannot pass by luck.
    frame_valid <= 1'b0;
    {frame_ident, frame_length, frame_data} <= ~{id, len, d};
  endtask
endmodule // can_node_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the receive buffer over APB.
// Assumes the node model feeds frames and the bench drives error events.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic err_inc, err_dec, err_recover, error_passive, bus_off, irq;
  logic frame_valid, frame_extended, frame_remote;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] err_step, frame_length;
  logic [28:0] frame_ident, id;
  logic [63:0] frame_data, dat;
  logic [3:0] len;
  logic ext, rtr;
  logic [32:0] exp_q[$];
  int n_fail = 0;
  int n_compared = 0;
  can_rx_buffer can_rx_buffer_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_valid(frame_valid), .frame_ident(frame_ident),
    .frame_extended(frame_extended), .frame_remote(frame_remote),
    .frame_length(frame_length), .frame_data(frame_data),
    .err_inc(err_inc), .err_step(err_step), .err_dec(err_dec),
    .err_recover(err_recover), .error_passive(error_passive),
    .bus_off(bus_off), .irq(irq));
  can_node_model can_node_model_inst (.ref_clk(ref_clk),
    .frame_valid(frame_valid), .frame_ident(frame_ident),
    .frame_extended(frame_extended), .frame_remote(frame_remote),
    .frame_length(frame_length), .frame_data(frame_data));
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Read results are matched against the oldest note at the sampling edge.
  always @(posedge ref_clk)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
        && pwrite === 1'b0)
      chk({pslverr, prdata}, exp_q.pop_front());
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] v);
    exp_q.push_back({25'h0, v});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic err(input logic i, input logic [3:0] s, input logic dn,
    input logic r);
    @(posedge ref_clk);
    {err_inc, err_step, err_dec, err_recover} <= {i, s, dn, r};
    @(posedge ref_clk);
    {err_inc, err_dec, err_recover} <= 3'b000;
    @(negedge ref_clk);
  endtask
  initial
  begin
    #(50 * 6000);
    n_fail++;
    complete_run;
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {err_inc, err_step, err_dec, err_recover} = '0;
    void'($urandom(32'h99800d7c));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(12'h018, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      {rtr, ext} = 2'(c);
      id = 29'($urandom);
      if (!ext) id[28:11] = 18'h0;
      len = (c == 2) ? 4'hf : 4'(8 - c);
      dat = {$urandom, $urandom};
      can_node_model_inst.send(ext, rtr, id, len, dat);
      rd(12'h000, ext ? id[28:21] : id[10:3]);
      rd(12'h004, {ext ? id[20:18] : id[2:0], rtr & !ext, ext, 1'b0,
        id[17:16]});
      rd(12'h008, ext ? id[15:8] : 8'h0);
      rd(12'h00c, ext ? id[7:0] : 8'h0);
      rd(12'h010, {1'b0, rtr, 2'b00, len});
      for (int i = 0; i < 8; i++)
        rd(12'(12'h040 + 4 * i), dat[63 - 8 * i -: 8]);
      rd(12'h014, {4'h8, rtr, 3'h0});
      apb(1'b1, 12'h014, 32'h0);
    end
    rd(12'h01c, 8'h01);
    apb(1'b1, 12'h01c, 32'h7);
    can_node_model_inst.send(1'b0, 1'b0, 29'h0, 4'h0, 64'h0);
    can_node_model_inst.send(1'b0, 1'b0, 29'h0, 4'h0, 64'h0);
    rd(12'h01c, 8'h05);
    apb(1'b1, 12'h004, 32'hff);
    rd(12'h004, 8'heb);
    apb(1'b1, 12'h010, 32'hff);
    rd(12'h010, 8'h4f);
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b1, 12'h01c, 32'h7);
    $display("frame test done");
    err(1'b0, 4'h0, 1'b0, 1'b1);
    repeat (8) err(1'b1, 4'hf, 1'b0, 1'b0);
    chk(33'(error_passive), 33'h0);
    apb(1'b1, 12'h018, 32'hff);
    rd(12'h018, 8'h78);
    err(1'b1, 4'h8, 1'b0, 1'b0);
    chk(33'(error_passive), 33'h1);
    chk(33'(bus_off), 33'h0);
    rd(12'h01c, 8'h02);
    chk(33'(irq), 33'h0);
    apb(1'b1, 12'h020, 32'h2);
    @(negedge ref_clk);
    chk(33'(irq), 33'h1);
    apb(1'b1, 12'h01c, 32'h2);
    @(negedge ref_clk);
    chk(33'(irq), 33'h0);
    err(1'b0, 4'h0, 1'b1, 1'b0);
    chk({32'h0, error_passive}, 33'h0);
    $display("error count test done");
    exp_q.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h024, 32'h0);
    $display("unmapped test done");
    repeat (2) @(posedge ref_clk);
    complete_run;
  end
endmodule // testbench
`default_nettype wire
